// [src/lcs_pkg.sv]
// Constants and layout of the main control and status register.
// What this block does
// R01 - New register value is old value ORed with fresh status.
// R02 - Bit 15 fault summary ORs overlength, heartbeat, dropped and bus-timeout flags.
// R03 - Fault summary is read-only; clears on reset, stop, or flags cleared.
// R04 - Bus-timeout flag, bit 11, sets when ready misses 25.6 us window.
// R05 - Bus timeout switches off receiver and transmitter; interrupt if enabled.
// R06 - Event flags set by hardware, write one clears, reset or stop clears.
// R07 - Receive-done flag, bit 10, sets on last receive entry or failure.
// R08 - Transmit-done flag, bit 09, sets on last transmit entry or failure.
// R09 - Setup-complete flag, bit 08, sets when parameter block is loaded.
// R10 - Interrupt flag, bit 07, ORs all event flags except heartbeat fault.
// R11 - Interrupt pin low only when enable bit 06 and flag are both one.
// R12 - Interrupt flag is read-only; clears on reset, stop, or causes cleared.
// R13 - Interrupt enable writable anytime; cleared by reset or stop.
// R14 - Receiver-active bit 05 sets on start after setup if receive enabled.
// R15 - Receiver-active clears on setup done with receive disabled, or timeout.
// R16 - Transmitter-active bit 04 sets on start after setup if transmit enabled; code needs only the setup bit, even in the same write, not setup done.
// R17 - Transmitter-active clears on setup with transmit disabled, timeout, underrun, chain fault.
// R18 - Both active bits read-only; cleared by reset or stop.
// R19 - Overlength flag sets after 1519 bytes sent; transmission continues.
// R20 - Dropped-frame flag sets when a frame is lost for lack of buffer.
// R21 - Setting stop halts activity and clears logic like reset.
// R22 - Register captured at slave read start; returned bits stay stable.
package lcs_pkg;

	// Register select values held in the address port
	localparam logic [1:0] LCS_SEL_MAIN = 2'h0;
	localparam int LCS_SEL_W = 2;

	// Bit positions of the main control and status register
	localparam int LCS_B_FAULT = 15;
	localparam int LCS_B_OVERLEN = 14;
	localparam int LCS_B_HBEAT = 13;
	localparam int LCS_B_DROP = 12;
	localparam int LCS_B_BUSTO = 11;
	localparam int LCS_B_RXDONE = 10;
	localparam int LCS_B_TXDONE = 9;
	localparam int LCS_B_SETUPDONE = 8;
	localparam int LCS_B_IRQ = 7;
	localparam int LCS_B_IEN = 6;
	localparam int LCS_B_RXACT = 5;
	localparam int LCS_B_TXACT = 4;
	localparam int LCS_B_TXDEMAND = 3;
	localparam int LCS_B_STOP = 2;
	localparam int LCS_B_RUN = 1;
	localparam int LCS_B_SETUP = 0;

	// Reset values
	localparam logic LCS_RST_STOP = 1'b1;
	localparam logic [15:0] LCS_RST_DATA = 16'h0000;
	localparam logic [1:0] LCS_RST_SEL = 2'h0;

	// Timing
	localparam int LCS_CLK_PERIOD_NS = 40;
	localparam int LCS_BUS_TIMEOUT_NS = 25600;
	localparam int LCS_BUS_TIMEOUT_CYC = LCS_BUS_TIMEOUT_NS / LCS_CLK_PERIOD_NS;
	localparam int LCS_OVERLEN_BYTES = 1519;

	// Slave port states
	typedef enum logic [1:0] {
		LCS_ST_IDLE = 2'b00,
		LCS_ST_ACCESS = 2'b01,
		LCS_ST_HOLD = 2'b10
	} lcs_slave_st_t;

endpackage : lcs_pkg

// [src/lcs_bus_timer.sv]
// Bus master ready-timeout watchdog.
`timescale 1ns/1ps
module lcs_bus_timer
	import lcs_pkg::*;
#(
	parameter int TIMEOUT_CYC = LCS_BUS_TIMEOUT_CYC,
	parameter int CNT_W = 10
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic soft_clr,
	// Master cycle
	input wire logic addr_strobe,
	input wire logic ready_in,
	// Result
	output logic timeout_pulse
);

	logic waiting_q;
	logic [CNT_W-1:0] cnt_q;
	logic expire;

	assign expire = waiting_q && !ready_in && (cnt_q == CNT_W'(TIMEOUT_CYC - 1));

	// Wait window opened by address, closed by ready or expiry
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			waiting_q <= 1'b0;
			cnt_q <= '0;
		end else if (soft_clr) begin
			waiting_q <= 1'b0;
			cnt_q <= '0;
		end else if (addr_strobe) begin
			waiting_q <= 1'b1;
			cnt_q <= '0;
		end else if (ready_in || expire) begin
			waiting_q <= 1'b0;
			cnt_q <= '0;
		end else if (waiting_q) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// One pulse when the window runs out
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			timeout_pulse <= 1'b0;
		end else begin
			timeout_pulse <= expire && !soft_clr; // R04
		end
	end

endmodule : lcs_bus_timer

// [src/lcs_tx_len_mon.sv]
// Transmit frame length monitor for overlength detection.
`timescale 1ns/1ps
module lcs_tx_len_mon
	import lcs_pkg::*;
#(
	parameter int LIMIT = LCS_OVERLEN_BYTES,
	parameter int CNT_W = 11
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic soft_clr,
	// Transmit progress
	input wire logic frame_start,
	input wire logic byte_sent,
	// Result
	output logic overlen_pulse
);

	logic [CNT_W-1:0] cnt_q;
	logic hit;

	assign hit = byte_sent && !frame_start && (cnt_q == CNT_W'(LIMIT - 1));

	// Byte count, saturating at the limit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (soft_clr || frame_start) begin
			cnt_q <= '0;
		end else if (byte_sent && cnt_q != CNT_W'(LIMIT)) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// Pulse once on the limiting byte; sending goes on regardless
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			overlen_pulse <= 1'b0;
		end else begin
			overlen_pulse <= hit && !soft_clr; // R19
		end
	end

endmodule : lcs_tx_len_mon

// [src/lcs_main_csr.sv]
// Main control and status register with slave port and status logic.
`timescale 1ns/1ps
module lcs_main_csr
	import lcs_pkg::*;
#(
	parameter int TIMEOUT_CYC = LCS_BUS_TIMEOUT_CYC,
	parameter int OVERLEN = LCS_OVERLEN_BYTES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Slave port
	input wire logic slave_cs_n,
	input wire logic slave_addr_port,
	input wire logic slave_write,
	input wire logic [15:0] slave_wdata,
	output logic [15:0] slave_rdata,
	output logic slave_ready,
	// Bus master cycle monitor
	input wire logic mst_addr_strobe,
	input wire logic mst_ready,
	// Setup engine
	input wire logic setup_done_evt,
	input wire logic rx_disable_cfg,
	input wire logic tx_disable_cfg,
	output logic setup_start,
	// Receive events
	input wire logic rx_last_entry_evt,
	input wire logic rx_fail_evt,
	input wire logic rx_drop_evt,
	// Transmit events
	input wire logic tx_frame_start,
	input wire logic tx_byte_sent,
	input wire logic tx_last_entry_evt,
	input wire logic tx_fail_evt,
	input wire logic tx_underrun,
	input wire logic tx_chain_fault,
	input wire logic heartbeat_fault_evt,
	// Status out
	output logic irq_n,
	output logic rx_active,
	output logic tx_active,
	output logic halt,
	output logic run_trigger,
	output logic tx_demand
);

	// Packs the readable view of the register
	function automatic logic [15:0] csr_pack(
		input logic ovl, input logic hb, input logic drp, input logic bto,
		input logic rxd, input logic txd, input logic sud, input logic ien,
		input logic rxa, input logic txa, input logic tdm, input logic stp,
		input logic run, input logic sup
	);
		logic [15:0] v;
		v = 16'h0000;
		v[LCS_B_FAULT] = ovl | hb | drp | bto;
		v[LCS_B_OVERLEN] = ovl;
		v[LCS_B_HBEAT] = hb;
		v[LCS_B_DROP] = drp;
		v[LCS_B_BUSTO] = bto;
		v[LCS_B_RXDONE] = rxd;
		v[LCS_B_TXDONE] = txd;
		v[LCS_B_SETUPDONE] = sud;
		v[LCS_B_IRQ] = ovl | drp | bto | rxd | txd | sud;
		v[LCS_B_IEN] = ien;
		v[LCS_B_RXACT] = rxa;
		v[LCS_B_TXACT] = txa;
		v[LCS_B_TXDEMAND] = tdm;
		v[LCS_B_STOP] = stp;
		v[LCS_B_RUN] = run;
		v[LCS_B_SETUP] = sup;
		return v;
	endfunction : csr_pack

	// Slave port state
	lcs_slave_st_t st_q;
	lcs_slave_st_t st_d;
	logic [LCS_SEL_W-1:0] sel_q;

	// Register state
	logic ovl_q;
	logic hb_q;
	logic drp_q;
	logic bto_q;
	logic rxd_q;
	logic txd_q;
	logic sud_q;
	logic ien_q;
	logic tdm_q;
	logic run_q;
	logic sup_q;
	logic loaded_q;

	// Decoded write strobes
	logic acc;
	logic main_wr;
	logic [15:0] w1;
	logic stop_set;
	logic run_set;
	logic sup_set;
	logic soft_clr;
	logic live;

	// Internal events
	logic bto_evt;
	logic ovl_evt;
	logic fault_sum;
	logic irq_sum;
	logic [15:0] csr_now;

	// Slave access sequencing
	always_comb begin
		st_d = st_q;
		case (st_q)
			LCS_ST_IDLE: begin
				if (!slave_cs_n) begin
					st_d = LCS_ST_ACCESS;
				end
			end
			LCS_ST_ACCESS: begin
				st_d = LCS_ST_HOLD;
			end
			LCS_ST_HOLD: begin
				if (slave_cs_n) begin
					st_d = LCS_ST_IDLE;
				end
			end
			default: begin
				st_d = LCS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= LCS_ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Write decode, taken once per access
	assign acc = (st_q == LCS_ST_ACCESS);
	assign main_wr = acc && slave_write && !slave_addr_port && (sel_q == LCS_SEL_MAIN);
	assign w1 = main_wr ? slave_wdata : 16'h0000;
	assign stop_set = w1[LCS_B_STOP];
	assign run_set = w1[LCS_B_RUN] && !stop_set;
	assign sup_set = w1[LCS_B_SETUP] && !stop_set;
	assign soft_clr = stop_set; // R21
	assign live = !halt && !soft_clr;

	// Register select port
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q <= LCS_RST_SEL;
		end else if (acc && slave_write && slave_addr_port) begin
			sel_q <= slave_wdata[LCS_SEL_W-1:0];
		end
	end

	// Read data latched at access start, steady until the next access
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slave_rdata <= LCS_RST_DATA;
		end else if (acc && !slave_write) begin
			if (slave_addr_port) begin
				slave_rdata <= {{(16 - LCS_SEL_W){1'b0}}, sel_q};
			end else if (sel_q == LCS_SEL_MAIN) begin
				slave_rdata <= csr_now; // R22
			end else begin
				slave_rdata <= LCS_RST_DATA;
			end
		end
	end

	// Ready answer while select is held
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slave_ready <= 1'b0;
		end else begin
			slave_ready <= (st_d == LCS_ST_HOLD);
		end
	end

	// Ready watchdog for master cycles
	lcs_bus_timer #(
		.TIMEOUT_CYC(TIMEOUT_CYC),
		.CNT_W(10)
	) u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.soft_clr(soft_clr || halt),
		.addr_strobe(mst_addr_strobe),
		.ready_in(mst_ready),
		.timeout_pulse(bto_evt)
	);

	// Transmit length watch
	lcs_tx_len_mon #(
		.LIMIT(OVERLEN),
		.CNT_W(11)
	) u_len (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.soft_clr(soft_clr || halt),
		.frame_start(tx_frame_start),
		.byte_sent(tx_byte_sent),
		.overlen_pulse(ovl_evt)
	);

	// Sticky event flags: old value kept, fresh events ORed in, set beats write-one clear, stop beats set
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ovl_q <= 1'b0;
			hb_q <= 1'b0;
			drp_q <= 1'b0;
			bto_q <= 1'b0;
			rxd_q <= 1'b0;
			txd_q <= 1'b0;
			sud_q <= 1'b0;
		end else if (soft_clr) begin
			ovl_q <= 1'b0; // R06
			hb_q <= 1'b0;
			drp_q <= 1'b0;
			bto_q <= 1'b0;
			rxd_q <= 1'b0;
			txd_q <= 1'b0;
			sud_q <= 1'b0;
		end else begin
			ovl_q <= (ovl_q && !w1[LCS_B_OVERLEN]) || (live && ovl_evt); // R01 R19
			hb_q <= (hb_q && !w1[LCS_B_HBEAT]) || (live && heartbeat_fault_evt);
			drp_q <= (drp_q && !w1[LCS_B_DROP]) || (live && rx_drop_evt); // R20
			bto_q <= (bto_q && !w1[LCS_B_BUSTO]) || (live && bto_evt); // R04 R06
			rxd_q <= (rxd_q && !w1[LCS_B_RXDONE])
				|| (live && (rx_last_entry_evt || rx_fail_evt)); // R07
			txd_q <= (txd_q && !w1[LCS_B_TXDONE])
				|| (live && (tx_last_entry_evt || tx_fail_evt)); // R08
			sud_q <= (sud_q && !w1[LCS_B_SETUPDONE]) || (live && setup_done_evt); // R09
		end
	end

	// Summaries follow the flags and so clear with them
	assign fault_sum = ovl_q | hb_q | drp_q | bto_q; // R02 R03
	assign irq_sum = ovl_q | drp_q | bto_q | rxd_q | txd_q | sud_q; // R10 R12

	// Interrupt enable, writable whether stopped or not
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ien_q <= 1'b0;
		end else if (soft_clr) begin
			ien_q <= 1'b0; // R13
		end else if (main_wr) begin
			ien_q <= slave_wdata[LCS_B_IEN]; // R13
		end
	end

	// Stop bit: set by reset or write one, left by run or setup
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			halt <= LCS_RST_STOP;
		end else if (stop_set) begin
			halt <= 1'b1; // R21
		end else if (run_set || sup_set) begin
			halt <= 1'b0;
		end
	end

	// Run and setup command bits, write one only
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			sup_q <= 1'b0;
			tdm_q <= 1'b0;
		end else if (soft_clr) begin
			run_q <= 1'b0;
			sup_q <= 1'b0;
			tdm_q <= 1'b0;
		end else begin
			run_q <= run_q || run_set;
			sup_q <= sup_q || sup_set;
			tdm_q <= (tdm_q || w1[LCS_B_TXDEMAND]) && !tx_frame_start;
		end
	end

	// One pulse to start the setup engine
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_start <= 1'b0;
		end else begin
			setup_start <= sup_set;
		end
	end

	// Parameter block loaded since the last stop
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			loaded_q <= 1'b0;
		end else if (soft_clr) begin
			loaded_q <= 1'b0;
		end else if (live && setup_done_evt) begin
			loaded_q <= 1'b1;
		end
	end

	// Receiver on indication
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_active <= 1'b0;
		end else if (soft_clr) begin
			rx_active <= 1'b0; // R18
		end else if (bto_evt) begin
			rx_active <= 1'b0; // R05 R15
		end else if (setup_done_evt && rx_disable_cfg) begin
			rx_active <= 1'b0; // R15
		end else if (run_set && loaded_q && !rx_disable_cfg) begin
			rx_active <= 1'b1; // R14
		end
	end

	// Transmitter on indication
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_active <= 1'b0;
		end else if (soft_clr) begin
			tx_active <= 1'b0; // R18
		end else if (bto_evt) begin
			tx_active <= 1'b0; // R05 R17
		end else if (tx_underrun || tx_chain_fault) begin
			tx_active <= 1'b0; // R17
		end else if (setup_done_evt && tx_disable_cfg) begin
			tx_active <= 1'b0; // R17
		end else if (run_set && (sup_q || sup_set) && !tx_disable_cfg) begin
			tx_active <= 1'b1; // R16
		end
	end

	// Interrupt pin, low only when enabled and flagged
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= !(ien_q && irq_sum); // R05 R11
		end
	end

	// Run and demand visible to the datapath
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_trigger <= 1'b0;
			tx_demand <= 1'b0;
		end else begin
			run_trigger <= run_q && !soft_clr;
			tx_demand <= tdm_q && !soft_clr;
		end
	end

	// Present view of the register
	assign csr_now = csr_pack(ovl_q, hb_q, drp_q, bto_q, rxd_q, txd_q, sud_q, ien_q,
		rx_active, tx_active, tdm_q, halt, run_q, sup_q);

endmodule : lcs_main_csr

// [sim/lcs_main_csr_sva.sv]
// Port checker for the main control and status register.
`timescale 1ns/1ps
module lcs_main_csr_chk
	import lcs_pkg::*;
#(
	parameter int TIMEOUT_CYC = LCS_BUS_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Slave port
	input wire logic slave_cs_n,
	input wire logic [15:0] slave_rdata,
	input wire logic slave_ready,
	// Master cycle
	input wire logic mst_addr_strobe,
	input wire logic mst_ready,
	// Status
	input wire logic setup_start,
	input wire logic irq_n,
	input wire logic rx_active,
	input wire logic tx_active,
	input wire logic halt,
	input wire logic run_trigger
);
	int wait_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Cycles of a master cycle left unanswered
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 0;
		end else if (mst_addr_strobe) begin
			wait_q <= 1;
		end else if (mst_ready) begin
			wait_q <= 0;
		end else if (wait_q != 0 && wait_q < TIMEOUT_CYC + 2) begin
			wait_q <= wait_q + 1;
		end
	end
	property p_rdy_rise; $fell(slave_cs_n) |=> !slave_ready ##1 slave_ready; endproperty
	a_rdy_rise: assert property (p_rdy_rise) else $error("ready late");
	property p_rdy_hold; slave_ready && !slave_cs_n |=> slave_ready; endproperty
	a_rdy_hold: assert property (p_rdy_hold) else $error("ready dropped");
	property p_rdy_drop; slave_ready && slave_cs_n |=> !slave_ready; endproperty
	a_rdy_drop: assert property (p_rdy_drop) else $error("ready stuck");
	property p_rdata_hold; !$rose(slave_ready) |-> $stable(slave_rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_halt_quiet; halt && $past(halt) |-> irq_n && !rx_active && !tx_active; endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("active while stopped");
	// Run pin lags the active bits by one registered stage
	property p_act_run;
		rx_active || tx_active |-> !halt && (run_trigger || $rose(rx_active || tx_active));
	endproperty
	a_act_run: assert property (p_act_run) else $error("active without run");
	property p_setup_pulse; setup_start |-> !halt ##1 !setup_start; endproperty
	a_setup_pulse: assert property (p_setup_pulse) else $error("setup pulse bad");
	property p_bto; wait_q == TIMEOUT_CYC + 2 |-> !rx_active && !tx_active; endproperty
	a_bto: assert property (p_bto) else $error("timeout kept active");
	// Main scenarios reached
	c_irq: cover property ($fell(irq_n));
	c_bto: cover property (wait_q == TIMEOUT_CYC + 2);
	c_stop: cover property ($rose(halt));
	c_setup: cover property (setup_start);
endmodule : lcs_main_csr_chk

bind lcs_main_csr lcs_main_csr_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) lcs_main_csr_chk_i (.core_clk,
	.rst_n, .slave_cs_n, .slave_rdata, .slave_ready, .mst_addr_strobe, .mst_ready,
	.setup_start, .irq_n, .rx_active, .tx_active, .halt, .run_trigger);

// [sim/lcs_host_model.sv]
// Host processor model driving the register slave port.
`timescale 1ns/1ps
module lcs_host_model (
	// Clock
	input wire logic core_clk,
	// Slave port
	output logic cs_n,
	output logic addr_port,
	output logic write,
	output logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic ready
);
	initial begin
		cs_n = 1'b1;
		addr_port = 1'b0;
		write = 1'b0;
		wdata = 16'h0000;
	end
	// One whole access; ok stays low if ready never comes or never drops
	task automatic xfer(input logic ap, input logic wr, input logic [15:0] d,
		output logic [15:0] q, output logic ok);
		ok = 1'b0;
		q = 16'h0000;
		@(negedge core_clk);
		cs_n = 1'b0;
		addr_port = ap;
		write = wr;
		wdata = d;
		for (int n = 0; n < 20 && !ok; n++) begin
			@(posedge core_clk);
			if (ready === 1'b1) begin
				q = rdata;
				ok = 1'b1;
			end
		end
		@(negedge core_clk);
		cs_n = 1'b1;
		wdata = ~wdata; // Released data lines do not keep the last value
		for (int n = 0; n < 20 && ready !== 1'b0; n++) begin
			@(posedge core_clk);
		end
		if (ready !== 1'b0) begin
			ok = 1'b0;
		end
	endtask : xfer
endmodule : lcs_host_model

// [sim/tb.sv]
// Self-checking bench for the main control and status register.
`timescale 1ns/1ps
module tb;
	import lcs_pkg::*;
	localparam int TO = 16;
	localparam int OVL = 20;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, ap, wr, rdy, irq_n, rxa, txa, halt, run, tdm, sst, rdis = 1'b0, tdis = 1'b0;
	logic mrdy = 1'b1;
	logic ld = 1'b0;
	logic ok;
	logic [15:0] wd, rdat, rq;
	logic [15:0] mreg = 16'h0004;
	logic [11:0] ev = 12'h000;
	logic [31:0] rnd = 32'h12FB;
	int n_mismatch = 0;
	int checks = 0;
	int nb = 0;
	int n_sst = 0;
	int e_sst = 0;
	always #20 core_clk = ~core_clk;
	// Setup start pulses seen by the bench
	always @(posedge core_clk) begin
		if (sst === 1'b1) begin
			n_sst++;
		end
	end
	lcs_main_csr #(.TIMEOUT_CYC(TO), .OVERLEN(OVL)) lcs_main_csr_i (.core_clk(core_clk),
		.rst_n(rst_n), .slave_cs_n(cs_n), .slave_addr_port(ap), .slave_write(wr),
		.slave_wdata(wd), .slave_rdata(rdat), .slave_ready(rdy), .mst_addr_strobe(ev[11]),
		.mst_ready(mrdy), .setup_done_evt(ev[8]), .rx_disable_cfg(rdis),
		.tx_disable_cfg(tdis), .setup_start(sst), .rx_last_entry_evt(ev[0]),
		.rx_fail_evt(ev[1]), .rx_drop_evt(ev[2]), .tx_frame_start(ev[9]),
		.tx_byte_sent(ev[10]), .tx_last_entry_evt(ev[3]), .tx_fail_evt(ev[4]),
		.tx_underrun(ev[6]), .tx_chain_fault(ev[7]), .heartbeat_fault_evt(ev[5]),
		.irq_n(irq_n), .rx_active(rxa), .tx_active(txa), .halt(halt), .run_trigger(run),
		.tx_demand(tdm));
	lcs_host_model host_i (.core_clk(core_clk), .cs_n(cs_n), .addr_port(ap), .write(wr),
		.wdata(wd), .rdata(rdat), .ready(rdy));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Register as read, with the two summary bits
	function automatic logic [15:0] exp_reg(input logic [15:0] m);
		exp_reg = m;
		exp_reg[15] = |(m & 16'h7800);
		exp_reg[7] = |(m & 16'h5F00);
	endfunction : exp_reg
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic a, input logic w, input logic [15:0] d);
		host_i.xfer(a, w, d, rq, ok);
		if (!ok) begin
			n_mismatch++;
			complete_run();
		end
	endtask : xfer
	// Read and compare register and status pins with the model
	task automatic rd();
		logic [15:0] e;
		e = exp_reg(mreg);
		xfer(1'b0, 1'b0, 16'h0000);
		chk(rq, e);
		chk({15'h0000, irq_n}, {15'h0000, ~(e[7] & e[6])});
		chk({11'h000, rxa, txa, tdm, halt, run}, {11'h000, e[5:1]});
	endtask : rd
	task automatic wrm(input logic [15:0] d);
		xfer(1'b0, 1'b1, d);
		if (d[2]) begin
			mreg = 16'h0004;
			ld = 1'b0;
		end else begin
			mreg[14:8] = mreg[14:8] & ~d[14:8];
			mreg[6] = d[6];
			mreg[2] = mreg[2] & ~(d[1] | d[0]);
			mreg[0] = mreg[0] | d[0];
			mreg[3] = mreg[3] | d[3];
			if (d[0]) begin
				e_sst++;
			end
			if (d[1]) begin
				mreg[1] = 1'b1;
				mreg[5] = mreg[5] | (ld & ~rdis);
				mreg[4] = mreg[4] | (mreg[0] & ~tdis);
			end
		end
	endtask : wrm
	// One event pulse, mirrored in the model
	task automatic pulse(input int i);
		@(negedge core_clk);
		ev[i] = 1'b1;
		@(negedge core_clk);
		ev[i] = 1'b0;
		if (!mreg[2]) begin
			case (i)
				0, 1: mreg[10] = 1'b1;
				2: mreg[12] = 1'b1;
				3, 4: mreg[9] = 1'b1;
				5: mreg[13] = 1'b1;
				6, 7: mreg[4] = 1'b0;
				8: begin
					ld = 1'b1;
					mreg[8] = 1'b1;
					mreg[5] = mreg[5] & ~rdis;
					mreg[4] = mreg[4] & ~tdis;
				end
				9: begin
					nb = 0;
					mreg[3] = 1'b0;
				end
				10: begin
					nb++;
					if (nb == OVL) mreg[14] = 1'b1;
				end
				default: ;
			endcase
		end
		repeat (2) @(negedge core_clk);
	endtask : pulse
	initial begin
		repeat (16) @(negedge core_clk);
		rst_n = 1'b1;
		rd();
		xfer(1'b1, 1'b1, 16'h0003);
		xfer(1'b0, 1'b1, 16'h0041);
		xfer(1'b0, 1'b0, 16'h0000);
		chk(rq, 16'h0000);
		xfer(1'b1, 1'b0, 16'h0000);
		chk(rq, 16'h0003);
		xfer(1'b1, 1'b1, 16'h0000);
		$display("test reset and select done");
		wrm(16'h0001);
		pulse(8);
		rd();
		wrm(16'h0042);
		rd();
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			rd();
			rnd = lfsr(rnd);
			wrm((rnd[15:0] & 16'hFFB0) | 16'h0040);
			rd();
		end
		$display("test event flags done");
		wrm(16'h0048);
		rd();
		pulse(9);
		for (int i = 0; i < OVL; i++) pulse(10);
		rd();
		for (int k = 0; k < 2; k++) begin
			@(negedge core_clk);
			mrdy = 1'b0;
			ev[11] = 1'b1;
			@(negedge core_clk);
			ev[11] = 1'b0;
			mrdy = (k == 0);
			repeat (TO + 4) @(negedge core_clk);
			mrdy = 1'b1;
			if (k == 1) begin
				mreg[11] = 1'b1;
				mreg[5:4] = 2'b00;
			end
			rd();
		end
		$display("test bus timeout done");
		wrm(16'h0042);
		pulse(6);
		pulse(7);
		rd();
		wrm(16'h0042);
		@(negedge core_clk);
		rdis = 1'b1;
		tdis = 1'b1;
		pulse(8);
		rd();
		wrm(16'h0042);
		rd();
		@(negedge core_clk);
		rdis = 1'b0;
		tdis = 1'b0;
		wrm(16'h7F00);
		pulse(2);
		rd();
		wrm(16'h0046);
		pulse(2);
		rd();
		$display("test stop done");
		chk(16'(n_sst), 16'(e_sst));
		complete_run();
	end
endmodule : tb
